// >>> ipfs_cfg.svh
// constants for the input pin function select block
//
// Behaviour
// - pin 1 function field is bits 6..4 of input_config_a, read/write, reset zero.
// - pin 2 function field is bits 2..0 of input_config_a, read/write, reset zero.
// - pin 3 function field is bits 6..4 of input_config_b at 0x2C, reset zero.
// - pin 4 function field is bits 2..0 of input_config_b, read/write, reset zero.
// - field value one makes the pin a general input visible to software.
// - field value two takes the master clock from the pin.
// - field value three makes the pin the daisy-chain serial data input.
// - values four to seven route the pin to PDM data pairs 12, 34, 56, 78.
// - bits 7 and 3 of both config registers are read-only zero.
// - read-only input_level_monitor at 0x2F, reset zero, shows general input levels.
// - monitor bits 7..4 show pins one..four as general inputs; bits 3..0 read zero.
// - input_config_a sits at 0x2B with reset value zero.
`ifndef IPFS_CFG_SVH
`define IPFS_CFG_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define IPFS_OFS_CONFIG_A   8'h2B
`define IPFS_OFS_CONFIG_B   8'h2C
`define IPFS_OFS_MONITOR    8'h2F

// ---------------------------------------------------------------
// field positions and reset values
// ---------------------------------------------------------------
`define IPFS_HI_FIELD_MSB   6
`define IPFS_HI_FIELD_LSB   4
`define IPFS_LO_FIELD_MSB   2
`define IPFS_LO_FIELD_LSB   0
`define IPFS_MON_LSB        4
`define IPFS_CONFIG_RESET   8'h00
`define IPFS_MONITOR_RESET  8'h00
`define IPFS_WRITE_MASK     8'h77

`endif

// >>> ipfs_pkg.sv
// types for the input pin function select block
package ipfs_pkg;
	typedef enum logic [2:0] {
		IPFS_FN_DISABLED = 3'h0,
		IPFS_FN_GENERAL  = 3'h1,
		IPFS_FN_MCLK     = 3'h2,
		IPFS_FN_CHAIN    = 3'h3,
		IPFS_FN_PDM12    = 3'h4,
		IPFS_FN_PDM34    = 3'h5,
		IPFS_FN_PDM56    = 3'h6,
		IPFS_FN_PDM78    = 3'h7
	} ipfs_func_t;
endpackage

// >>> ipfs_pin_route.sv
// routes synchronised pin levels to the selected destinations
`timescale 1ns/100ps
module ipfs_pin_route
	import ipfs_pkg::*;
#(
	parameter int PINS = 4
) (
	// selects and levels
	input  wire logic [3*PINS-1:0] sel_in,
	input  wire logic [PINS-1:0]   level_in,
	// destinations
	output logic                   mclk_valid_out,
	output logic                   mclk_out,
	output logic                   chain_valid_out,
	output logic                   chain_out,
	output logic [3:0]             pdm_valid_out,
	output logic [3:0]             pdm_out
);
	// a destination takes the first (lowest) pin whose select names it
	function automatic logic [1:0] pick(input logic [3*PINS-1:0] s, input ipfs_func_t f,
		input logic [PINS-1:0] lv);
		logic v;
		logic d;
		v = 1'b0;
		d = 1'b0;
		for (int p = PINS - 1; p >= 0; p--) begin
			if (s[3*p +: 3] == f) begin
				v = 1'b1;
				d = lv[p];
			end
		end
		return {v, d};
	endfunction

	always_comb begin
		logic [1:0] r;
		r = pick(sel_in, IPFS_FN_MCLK, level_in);
		mclk_valid_out = r[1];
		mclk_out = r[0];
		r = pick(sel_in, IPFS_FN_CHAIN, level_in);
		chain_valid_out = r[1];
		chain_out = r[0];
		for (int k = 0; k < 4; k++) begin
			r = pick(sel_in, ipfs_func_t'(3'(k + 4)), level_in);
			pdm_valid_out[k] = r[1];
			pdm_out[k] = r[0];
		end
	end
endmodule

// >>> ipfs_input_pin_function_select.sv
// top of the input pin function select block: registers, pin sync, routing
`include "ipfs_cfg.svh"
`timescale 1ns/100ps
module ipfs_input_pin_function_select
	import ipfs_pkg::*;
(
	// clock and reset
	input  wire logic       ref_clk_in,
	input  wire logic       rst_in,
	// register port
	input  wire logic [7:0] addr_in,
	input  wire logic [7:0] wdata_in,
	input  wire logic       wr_in,
	input  wire logic       rd_in,
	output logic [7:0]      rdata_out,
	// shared pins
	input  wire logic       shared_input_pin1_in,
	input  wire logic       shared_input_pin2_in,
	input  wire logic       shared_input_pin3_in,
	input  wire logic       shared_input_pin4_in,
	// clock source
	input  wire logic       dedicated_mclk_in,
	output logic            mclk_from_pin_out,
	output logic            mclk_sel_out,
	// audio destinations
	output logic            chain_serial_data_in_out,
	output logic            chain_valid_out,
	output logic [3:0]      pdm_data_out,
	output logic [3:0]      pdm_valid_out
);
	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	logic [7:0] config_a_reg;
	logic [7:0] config_b_reg;
	logic [7:0] monitor_reg;
	logic [7:0] rdata_reg;
	logic [3:0] sync1_reg;
	logic [3:0] sync2_reg;
	logic [3:0] mon_next;
	logic [11:0] sel_all;
	logic       mclk_v;
	logic       mclk_d;

	// writes keep reserved bits 7 and 3 at zero
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			config_a_reg <= `IPFS_CONFIG_RESET;
		end else if (wr_in && addr_in == `IPFS_OFS_CONFIG_A) begin
			config_a_reg <= wdata_in & `IPFS_WRITE_MASK;
		end
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			config_b_reg <= `IPFS_CONFIG_RESET;
		end else if (wr_in && addr_in == `IPFS_OFS_CONFIG_B) begin
			config_b_reg <= wdata_in & `IPFS_WRITE_MASK;
		end
	end

	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			sync1_reg <= 4'h0;
			sync2_reg <= 4'h0;
		end else begin
			sync1_reg <= {shared_input_pin4_in, shared_input_pin3_in,
				shared_input_pin2_in, shared_input_pin1_in};
			sync2_reg <= sync1_reg;
		end
	end

	assign sel_all = {config_b_reg[`IPFS_LO_FIELD_MSB:`IPFS_LO_FIELD_LSB],
		config_b_reg[`IPFS_HI_FIELD_MSB:`IPFS_HI_FIELD_LSB],
		config_a_reg[`IPFS_LO_FIELD_MSB:`IPFS_LO_FIELD_LSB],
		config_a_reg[`IPFS_HI_FIELD_MSB:`IPFS_HI_FIELD_LSB]};

	// ---------------------------------------------------------------
	// level monitor
	// ---------------------------------------------------------------
	// non-general pins read zero so a disabled pin leaks nothing
	always_comb begin
		for (int p = 0; p < 4; p++) begin
			mon_next[p] = (sel_all[3*p +: 3] == IPFS_FN_GENERAL) && sync2_reg[p];
		end
	end

	// pin 1 sits in bit 7, pin 4 in bit 4
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			monitor_reg <= `IPFS_MONITOR_RESET;
		end else begin
			monitor_reg <= {mon_next[0], mon_next[1], mon_next[2], mon_next[3], 4'h0};
		end
	end

	// ---------------------------------------------------------------
	// read port
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			rdata_reg <= 8'h00;
		end else if (rd_in) begin
			case (addr_in)
				`IPFS_OFS_CONFIG_A: rdata_reg <= config_a_reg;
				`IPFS_OFS_CONFIG_B: rdata_reg <= config_b_reg;
				`IPFS_OFS_MONITOR:  rdata_reg <= monitor_reg;
				default:            rdata_reg <= 8'h00;
			endcase
		end else begin
			rdata_reg <= 8'h00;
		end
	end
	assign rdata_out = rdata_reg;

	// ---------------------------------------------------------------
	// routing
	// ---------------------------------------------------------------
	ipfs_pin_route #(
		.PINS(4)
	) u_route (
		.sel_in          (sel_all),
		.level_in        (sync2_reg),
		.mclk_valid_out  (mclk_v),
		.mclk_out        (mclk_d),
		.chain_valid_out (chain_valid_out),
		.chain_out       (chain_serial_data_in_out),
		.pdm_valid_out   (pdm_valid_out),
		.pdm_out         (pdm_data_out)
	);

	// pin clock is sampled, so it must be well under half the 40 MHz rate
	assign mclk_sel_out      = mclk_v;
	assign mclk_from_pin_out = mclk_v ? mclk_d : dedicated_mclk_in;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	a_cfg_reserved_zero: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		config_a_reg[7] == 1'b0 && config_a_reg[3] == 1'b0 && config_b_reg[7] == 1'b0
		&& config_b_reg[3] == 1'b0) else $error("reserved config bit set");
	a_cfg_a_write: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		wr_in && addr_in == 8'h2B |=> config_a_reg[6:4] == $past(wdata_in[6:4]))
		else $error("pin1 field not written");
	a_cfg_a_low: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		wr_in && addr_in == 8'h2B |=> config_a_reg[2:0] == $past(wdata_in[2:0]))
		else $error("pin2 field not written");
	a_cfg_b_write: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		wr_in && addr_in == 8'h2C |=> config_b_reg[6:4] == $past(wdata_in[6:4]))
		else $error("pin3 field not written");
	a_cfg_b_low: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		wr_in && addr_in == 8'h2C |=> config_b_reg[2:0] == $past(wdata_in[2:0]))
		else $error("pin4 field not written");
	a_mon_general: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		config_a_reg[6:4] == 3'h1 && $stable(config_a_reg) |=> monitor_reg[7] == $past(sync2_reg[0]))
		else $error("pin1 level not monitored");
	a_mon_disabled: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		config_b_reg[2:0] != 3'h1 |=> monitor_reg[4] == 1'b0) else $error("pin4 level leaked");
	a_mon_low_zero: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		monitor_reg[3:0] == 4'h0) else $error("monitor reserved bits set");
	a_mon_read: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		rd_in && addr_in == 8'h2F |=> rdata_out == $past(monitor_reg)) else $error("monitor read wrong");
	a_mclk_select: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		config_a_reg[6:4] == 3'h2 |-> mclk_sel_out && mclk_from_pin_out == sync2_reg[0])
		else $error("mclk not taken from pin1");
	a_chain_route: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		config_b_reg[6:4] == 3'h3 && config_a_reg[6:4] != 3'h3 && config_a_reg[2:0] != 3'h3
		|-> chain_valid_out && chain_serial_data_in_out == sync2_reg[2]) else $error("chain route wrong");
	a_pdm_route: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		config_a_reg[2:0] == 3'h6 && config_a_reg[6:4] != 3'h6
		|-> pdm_valid_out[2] && pdm_data_out[2] == sync2_reg[1]) else $error("pdm route wrong");
	a_priority_low: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		config_a_reg[6:4] == 3'h4 |-> pdm_data_out[0] == sync2_reg[0]) else $error("priority wrong");
	// the other three monitor bits, each with its own pin and field
	a_mon_pin2: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		config_a_reg[2:0] == 3'h1 && $stable(config_a_reg) |=> monitor_reg[6] == $past(sync2_reg[1]))
		else $error("pin2 level not monitored");
	a_mon_pin3: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		config_b_reg[6:4] == 3'h1 && $stable(config_b_reg) |=> monitor_reg[5] == $past(sync2_reg[2]))
		else $error("pin3 level not monitored");
	a_mon_pin4: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		config_b_reg[2:0] == 3'h1 && $stable(config_b_reg) |=> monitor_reg[4] == $past(sync2_reg[3]))
		else $error("pin4 level not monitored");
	// with no pin on the clock function the dedicated source must pass straight through
	a_mclk_default: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		config_a_reg[6:4] != 3'h2 && config_a_reg[2:0] != 3'h2 && config_b_reg[6:4] != 3'h2
		&& config_b_reg[2:0] != 3'h2 |-> !mclk_sel_out && mclk_from_pin_out == dedicated_mclk_in)
		else $error("mclk not from dedicated source");
	a_pdm_unused: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		config_a_reg[6:4] != 3'h4 && config_a_reg[2:0] != 3'h4 && config_b_reg[6:4] != 3'h4
		&& config_b_reg[2:0] != 3'h4 |-> !pdm_valid_out[0] && !pdm_data_out[0])
		else $error("unused pdm pair driven");
	a_chain_pin1: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		config_a_reg[6:4] == 3'h3 |-> chain_valid_out && chain_serial_data_in_out == sync2_reg[0])
		else $error("pin1 chain priority wrong");
	// read data stands one cycle only, so a stale value never looks like an answer
	a_rdata_idle: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		!rd_in |=> rdata_out == 8'h00) else $error("read data not cleared");

	c_mclk_pin: cover property (@(posedge ref_clk_in) mclk_sel_out);
	c_chain: cover property (@(posedge ref_clk_in) chain_valid_out);
	c_all_pdm: cover property (@(posedge ref_clk_in) pdm_valid_out == 4'hF);
	c_mon_high: cover property (@(posedge ref_clk_in) monitor_reg[7:4] == 4'hF);
endmodule

// >>> ipfs_far_side_model.sv
// far side model: sources that drive the shared pins and the dedicated clock
`timescale 1ns/100ps
module ipfs_far_side_model (
	// bench control
	input  wire logic       ref_clk_in,
	input  wire logic [3:0] level_in,
	// pins, index 0 is pin one
	output logic [3:0]      pin_out,
	output logic            mclk_out
);
	// the pins are plain levels that the bench steps; the clock source runs free
	assign pin_out = level_in;
	initial mclk_out = 1'b0;
	always @(posedge ref_clk_in) begin
		mclk_out <= ~mclk_out;
	end
endmodule

// >>> ipfs_input_pin_function_select_test.sv
// self-checking bench for the input pin function select block
`include "ipfs_cfg.svh"
`timescale 1ns/100ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin n_fail++; \
	$display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module ipfs_input_pin_function_select_test;
	logic       ref_clk_in;
	logic       rst_in;
	logic       wr_in;
	logic       rd_in;
	logic [7:0] addr_in;
	logic [7:0] wdata_in;
	logic [7:0] rdata_out;
	logic [3:0] level;
	logic [3:0] pin;
	logic       mclk;
	logic       mclk_from_pin_out;
	logic       mclk_sel_out;
	logic       chain_out;
	logic       chain_valid_out;
	logic [3:0] pdm_data_out;
	logic [3:0] pdm_valid_out;
	logic [3:0] exp_pdm;
	int         n_fail = 0;
	int         checked = 0;
	int         cycles = 0;

	ipfs_far_side_model far (.ref_clk_in(ref_clk_in), .level_in(level), .pin_out(pin),
		.mclk_out(mclk));
	ipfs_input_pin_function_select uut (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
		.addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
		.rdata_out(rdata_out), .shared_input_pin1_in(pin[0]), .shared_input_pin2_in(pin[1]),
		.shared_input_pin3_in(pin[2]), .shared_input_pin4_in(pin[3]),
		.dedicated_mclk_in(mclk), .mclk_from_pin_out(mclk_from_pin_out),
		.mclk_sel_out(mclk_sel_out), .chain_serial_data_in_out(chain_out),
		.chain_valid_out(chain_valid_out), .pdm_data_out(pdm_data_out),
		.pdm_valid_out(pdm_valid_out));

	// ---------------------------------------------------------------
	// access tasks
	// ---------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk_in);
		wr_in <= 1'b1;
		addr_in <= a;
		wdata_in <= d;
		@(posedge ref_clk_in);
		wr_in <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge ref_clk_in);
		rd_in <= 1'b1;
		addr_in <= a;
		@(posedge ref_clk_in);
		rd_in <= 1'b0;
		#1;
		`CHK(rdata_out, e)
	endtask
	// three edges cover the two-stage sync plus the monitor register
	task automatic pins(input logic [3:0] l);
		@(posedge ref_clk_in);
		level <= l;
		repeat (3) @(posedge ref_clk_in);
		#1;
	endtask
	task automatic results();
		$display("checked %0d, n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// ---------------------------------------------------------------
	// clock, timeout
	// ---------------------------------------------------------------
	initial begin
		ref_clk_in = 1'b0;
		forever #12.5 ref_clk_in = ~ref_clk_in;
	end
	always @(posedge ref_clk_in) begin
		cycles++;
		if (cycles == 2000) begin
			n_fail++;
			results();
		end
	end

	// ---------------------------------------------------------------
	// tests
	// ---------------------------------------------------------------
	initial begin
		rst_in = 1'b1;
		wr_in = 1'b0;
		rd_in = 1'b0;
		addr_in = 8'h00;
		wdata_in = 8'h00;
		level = 4'h0;
		repeat (2) @(posedge ref_clk_in);
		rst_in <= 1'b0;
		rd(`IPFS_OFS_CONFIG_A, 8'h00);
		rd(`IPFS_OFS_CONFIG_B, 8'h00);
		rd(`IPFS_OFS_MONITOR, 8'h00);
		wr(`IPFS_OFS_CONFIG_A, 8'hFF);
		rd(`IPFS_OFS_CONFIG_A, 8'h77);
		wr(`IPFS_OFS_CONFIG_B, 8'hFF);
		rd(`IPFS_OFS_CONFIG_B, 8'h77);
		wr(`IPFS_OFS_MONITOR, 8'hFF);
		rd(`IPFS_OFS_MONITOR, 8'h00);
		rd(8'h2D, 8'h00);
		wr(`IPFS_OFS_CONFIG_B, 8'h00);
		// every function code on pin one, pin high then low
		for (int v = 0; v < 8; v++) begin
			wr(`IPFS_OFS_CONFIG_A, {1'b0, v[2:0], 4'h0});
			pins(4'h1);
			exp_pdm = (v >= 4) ? (4'h1 << (v - 4)) : 4'h0;
			`CHK(mclk_sel_out, v == 2)
			`CHK(mclk_from_pin_out, (v == 2) ? 1'b1 : mclk)
			`CHK(chain_valid_out, v == 3)
			`CHK(chain_out, v == 3)
			`CHK(pdm_valid_out, exp_pdm)
			`CHK(pdm_data_out, exp_pdm)
			rd(`IPFS_OFS_MONITOR, (v == 1) ? 8'h80 : 8'h00);
			pins(4'h0);
			`CHK(mclk_from_pin_out, (v == 2) ? 1'b0 : mclk)
			`CHK(pdm_data_out, 4'h0)
		end
		wr(`IPFS_OFS_CONFIG_A, 8'h11);
		wr(`IPFS_OFS_CONFIG_B, 8'h11);
		pins(4'b0101);
		rd(`IPFS_OFS_MONITOR, 8'hA0);
		pins(4'b1010);
		rd(`IPFS_OFS_MONITOR, 8'h50);
		// pins two and four both claim the chain input; pin two must win
		wr(`IPFS_OFS_CONFIG_A, 8'h03);
		wr(`IPFS_OFS_CONFIG_B, 8'h03);
		pins(4'b1000);
		`CHK(chain_out, 1'b0)
		`CHK(chain_valid_out, 1'b1)
		pins(4'b0010);
		`CHK(chain_out, 1'b1)
		// reset in mid-run clears the fields again
		@(posedge ref_clk_in);
		rst_in <= 1'b1;
		@(posedge ref_clk_in);
		rst_in <= 1'b0;
		rd(`IPFS_OFS_CONFIG_A, 8'h00);
		rd(`IPFS_OFS_CONFIG_B, 8'h00);
		results();
	end
endmodule
